// >>> design/wdc_pkg.sv
package wdc_pkg;

    // ***********************************************
    // Register addresses on the SFR port
    // ***********************************************
    localparam logic [7:0] WDC_ADDR_TA   = 8'hc7;
    localparam logic [7:0] WDC_ADDR_CTRL = 8'hd8;
    localparam logic [7:0] WDC_ADDR_EIE  = 8'he8;
    localparam logic [7:0] WDC_ADDR_EIP  = 8'hf8;

    // ***********************************************
    // Watchdog control and extended enable/priority field positions
    // ***********************************************
    localparam int unsigned WDC_B_UNIMPL = 7;
    localparam int unsigned WDC_B_PWRUP  = 6;
    localparam int unsigned WDC_B_UEN    = 5;
    localparam int unsigned WDC_B_UFLAG  = 4;
    localparam int unsigned WDC_B_WIFLAG = 3;
    localparam int unsigned WDC_B_WRFLAG = 2;
    localparam int unsigned WDC_B_WREN   = 1;
    localparam int unsigned WDC_B_RESTRT = 0;
    localparam int unsigned WDC_B_WDIRQ  = 4;

    // ***********************************************
    // Reset, read-back and key values
    // ***********************************************
    localparam logic [7:0] WDC_EXT_RST_VAL = 8'hef;
    localparam logic [7:0] WDC_TA_READ     = 8'hff;
    localparam logic [7:0] WDC_KEY_FIRST   = 8'haa;
    localparam logic [7:0] WDC_KEY_SECOND  = 8'h55;
    localparam logic [7:0] WDC_RD_IDLE     = 8'h00;

    // ***********************************************
    // Timing
    // ***********************************************
    localparam int unsigned WDC_MC_CLKS       = 4;
    localparam int unsigned WDC_TA_WINDOW_MC  = 3;
    localparam int unsigned WDC_TA_WINDOW_CLK = WDC_MC_CLKS * WDC_TA_WINDOW_MC;
    localparam int unsigned WDC_TA_CNT_W      = 4;
    localparam int unsigned WDC_RST_DELAY_CLK = 512;
    localparam int unsigned WDC_DLY_W         = 10;
    localparam int unsigned WDC_CNT_W         = 27;
    localparam int unsigned WDC_LOG2_STEP     = 3;

    // Address match shared by the read and write decoders
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

endpackage

// >>> design/wdc_timed_access.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_timed_access (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       key_wr,
    input  wire logic       other_wr,
    input  wire logic [7:0] key_data,
    output logic            window_open
);
    logic                               armed_ff;
    logic [wdc_pkg::WDC_TA_CNT_W-1:0]   win_ff;

    // ***********************************************
    // Key sequence
    // ***********************************************
    // first key arms
    // Any other write between the keys breaks the sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_ff <= 1'b0;
        end else if (key_wr) begin
            armed_ff <= (key_data == wdc_pkg::WDC_KEY_FIRST);
        end else if (other_wr) begin
            armed_ff <= 1'b0;
        end
    end

    // window of three
    // Second key loads twelve clocks, i.e. three machine cycles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_ff <= '0;
        end else if (key_wr && armed_ff &&
                     key_data == wdc_pkg::WDC_KEY_SECOND) begin
            win_ff <= wdc_pkg::WDC_TA_CNT_W'(wdc_pkg::WDC_TA_WINDOW_CLK);
        end else if (win_ff != '0) begin
            win_ff <= win_ff - 1'b1;
        end
    end

    assign window_open = (win_ff != '0);

endmodule
`default_nettype wire

// >>> design/wdc_wd_timer.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_wd_timer #(
    parameter int unsigned BASE_LOG2 = 17
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] period_sel,
    input  wire logic       reset_enable,
    input  wire logic       restart,
    output logic            timeout,
    output logic            cpu_reset
);
    logic [wdc_pkg::WDC_CNT_W-1:0] cnt_ff;
    logic [wdc_pkg::WDC_CNT_W-1:0] mask;
    logic [wdc_pkg::WDC_DLY_W-1:0] dly_ff;
    logic                          pend_ff;
    logic                          hit;
    int unsigned                   log2;

    always_comb begin
        log2 = BASE_LOG2 + wdc_pkg::WDC_LOG2_STEP * int'(period_sel);
        mask = {wdc_pkg::WDC_CNT_W{1'b1}} >> (wdc_pkg::WDC_CNT_W - log2);
        hit  = ((cnt_ff & mask) == mask);
    end

    // runs on through external resets; rst, a restart or its own processor reset clears it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (restart || cpu_reset) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Timeout is a single-cycle event
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timeout <= 1'b0;
        end else begin
            timeout <= hit && !restart;
        end
    end

    // delayed reset
    // Restart inside the delay cancels the pending processor reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_ff   <= 1'b0;
            dly_ff    <= '0;
            cpu_reset <= 1'b0;
        end else begin
            cpu_reset <= 1'b0;
            if (restart) begin
                pend_ff <= 1'b0;
            end else if (pend_ff) begin
                dly_ff <= dly_ff + 1'b1;
                if (dly_ff == wdc_pkg::WDC_DLY_W'(
                        wdc_pkg::WDC_RST_DELAY_CLK - 1)) begin
                    pend_ff <= 1'b0;
                    cpu_reset <= reset_enable;
                end
            end else if (hit && reset_enable) begin
                pend_ff <= 1'b1;
                dly_ff  <= '0;
            end
        end
    end

endmodule
`default_nettype wire

// >>> design/wdc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl #(
    parameter int unsigned BASE_LOG2 = 17
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ext_reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic [1:0] wd_period_sel,
    input  wire logic       urgent_irq_input,
    input  wire logic       global_irq_enable,
    output logic            urgent_irq_req,
    output logic            wd_irq_req,
    output logic            wd_irq_high_prio,
    output logic            wd_cpu_reset,
    output logic            ta_window_open
);

    // ***********************************************
    // Declarations
    // ***********************************************
    logic       pwrup_ff;
    logic       uen_ff;
    logic       uflag_ff;
    logic       wiflag_ff;
    logic       wrflag_ff;
    logic       wren_ff;
    logic       restart_ff;
    logic       wdirq_en_ff;
    logic       wdirq_pri_ff;
    logic [7:0] sfr_rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] ctrl_view;
    logic       wr_ta;
    logic       wr_ctrl;
    logic       wr_eie;
    logic       wr_eip;
    logic       wr_other;
    logic       wr_prot;
    logic       sys_rst;
    logic       wd_timeout;
    logic       window_open;

    // ***********************************************
    // Write decode
    // ***********************************************
    // One decoder function serves reads and writes alike
    assign wr_ta    = sfr_wr && wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_TA);
    assign wr_ctrl  = sfr_wr && wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_CTRL);
    assign wr_eie   = sfr_wr && wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_EIE);
    assign wr_eip   = sfr_wr && wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_EIP);
    assign wr_other = sfr_wr && !wr_ta;

    // protected write gate
    // The window is sampled as the write lands, not when it was opened
    assign wr_prot  = wr_ctrl && window_open;

    // Any processor reset: external pin or the watchdog's own
    assign sys_rst  = ext_reset || wd_cpu_reset;

    // ***********************************************
    // Timed access unit
    // ***********************************************
    wdc_timed_access u_ta (
        .core_clk    (core_clk),
        .rst         (rst),
        .key_wr      (wr_ta),
        .other_wr    (wr_other),
        .key_data    (sfr_wdata),
        .window_open (window_open)
    );

    assign ta_window_open = window_open;

    // ***********************************************
    // Watchdog counter and delayed reset
    // ***********************************************
    // period follows select
    // The select input is expected to drop to its minimum after any
    // processor reset; this block does not second-guess it
    wdc_wd_timer #(
        .BASE_LOG2    (BASE_LOG2)
    ) u_timer (
        .core_clk     (core_clk),
        .rst          (rst),
        .period_sel   (wd_period_sel),
        .reset_enable (wren_ff),
        .restart      (restart_ff),
        .timeout      (wd_timeout),
        .cpu_reset    (wd_cpu_reset)
    );

    // ***********************************************
    // Power-up flag
    // ***********************************************
    // power-up flag
    // power-on sets it
    // Only the power-on reset touches it; protected writes set or clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwrup_ff <= 1'b1;
        end else if (wr_prot) begin
            pwrup_ff <= sfr_wdata[wdc_pkg::WDC_B_PWRUP];
        end
    end

    // ***********************************************
    // Urgent interrupt enable and flag
    // ***********************************************
    // enable cleared
    // Enable is an unprotected bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            uen_ff <= 1'b0;
        end else if (sys_rst) begin
            uen_ff <= 1'b0;
        end else if (wr_ctrl) begin
            uen_ff <= sfr_wdata[wdc_pkg::WDC_B_UEN];
        end
    end

    // sticky urgent flag
    // Input set wins over a software clear in the same cycle, so an
    // event arriving during the clear is never lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            uflag_ff <= 1'b0;
        end else if (urgent_irq_input && uen_ff) begin
            uflag_ff <= 1'b1;
        end else if (wr_ctrl) begin
            uflag_ff <= sfr_wdata[wdc_pkg::WDC_B_UFLAG];
        end
    end

    assign urgent_irq_req = uen_ff && uflag_ff;

    // ***********************************************
    // Watchdog interrupt flag
    // ***********************************************
    // timeout sets flag
    // cleared by reset
    // The timeout beats both the reset pattern and a software clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wiflag_ff <= 1'b0;
        end else if (wd_timeout) begin
            wiflag_ff <= 1'b1;
        end else if (sys_rst) begin
            wiflag_ff <= 1'b0;
        end else if (wr_prot) begin
            wiflag_ff <= sfr_wdata[wdc_pkg::WDC_B_WIFLAG];
        end
    end

    assign wd_irq_req = global_irq_enable && wdirq_en_ff && wiflag_ff;

    // ***********************************************
    // Watchdog reset flag
    // ***********************************************
    // cause flag
    // untouched when disabled
    // External reset leaves it alone so software can tell causes apart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrflag_ff <= 1'b0;
        end else if (wd_cpu_reset && wren_ff) begin
            wrflag_ff <= 1'b1;
        end else if (wr_prot) begin
            wrflag_ff <= sfr_wdata[wdc_pkg::WDC_B_WRFLAG];
        end
    end

    // ***********************************************
    // Watchdog reset enable
    // ***********************************************
    // reset enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wren_ff <= 1'b0;
        end else if (wr_prot) begin
            wren_ff <= sfr_wdata[wdc_pkg::WDC_B_WREN];
        end
    end

    // ***********************************************
    // Restart strobe
    // ***********************************************
    // self-clearing restart
    // Held for one clock only; reading it back almost always gives zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            restart_ff <= 1'b0;
        end else if (sys_rst) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= wr_prot && sfr_wdata[wdc_pkg::WDC_B_RESTRT];
        end
    end

    // ***********************************************
    // Extended enable and priority
    // ***********************************************
    // watchdog irq enable
    // Cleared on every reset, as the EFh reset value implies
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdirq_en_ff <= 1'b0;
        end else if (sys_rst) begin
            wdirq_en_ff <= 1'b0;
        end else if (wr_eie) begin
            wdirq_en_ff <= sfr_wdata[wdc_pkg::WDC_B_WDIRQ];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdirq_pri_ff <= 1'b0;
        end else if (sys_rst) begin
            wdirq_pri_ff <= 1'b0;
        end else if (wr_eip) begin
            wdirq_pri_ff <= sfr_wdata[wdc_pkg::WDC_B_WDIRQ];
        end
    end

    assign wd_irq_high_prio = wdirq_pri_ff;

    // ***********************************************
    // Read path
    // ***********************************************
    // top bit reads one
    always_comb begin
        ctrl_view                         = '0;
        ctrl_view[wdc_pkg::WDC_B_UNIMPL]  = 1'b1;
        ctrl_view[wdc_pkg::WDC_B_PWRUP]   = pwrup_ff;
        ctrl_view[wdc_pkg::WDC_B_UEN]     = uen_ff;
        ctrl_view[wdc_pkg::WDC_B_UFLAG]   = uflag_ff;
        ctrl_view[wdc_pkg::WDC_B_WIFLAG]  = wiflag_ff;
        ctrl_view[wdc_pkg::WDC_B_WRFLAG]  = wrflag_ff;
        ctrl_view[wdc_pkg::WDC_B_WREN]    = wren_ff;
        ctrl_view[wdc_pkg::WDC_B_RESTRT]  = restart_ff;
    end

    // Reserved enable and priority bits read high
    always_comb begin
        nxt_rdata = wdc_pkg::WDC_RD_IDLE;
        if (wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_CTRL)) begin
            nxt_rdata = ctrl_view;
        end else if (wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_TA)) begin
            nxt_rdata = wdc_pkg::WDC_TA_READ;
        end else if (wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_EIE)) begin
            nxt_rdata = wdc_pkg::WDC_EXT_RST_VAL;
            nxt_rdata[wdc_pkg::WDC_B_WDIRQ] = wdirq_en_ff;
        end else if (wdc_pkg::hit(sfr_addr, wdc_pkg::WDC_ADDR_EIP)) begin
            nxt_rdata = wdc_pkg::WDC_EXT_RST_VAL;
            nxt_rdata[wdc_pkg::WDC_B_WDIRQ] = wdirq_pri_ff;
        end
    end

    // Read data is registered on the strobe and held until the next read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_ff <= wdc_pkg::WDC_RD_IDLE;
        end else if (sfr_rd) begin
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata = sfr_rdata_ff;

endmodule
`default_nettype wire

// >>> testbench/wdc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_monitor #(
    parameter int unsigned BASE_LOG2 = 17
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       ext_reset,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] wd_period_sel,
    input wire logic       urgent_irq_input,
    input wire logic       global_irq_enable,
    input wire logic       urgent_irq_req,
    input wire logic       wd_irq_req,
    input wire logic       wd_irq_high_prio,
    input wire logic       wd_cpu_reset,
    input wire logic       ta_window_open
);
    // ***********************************************
    // Window length tracking
    // ***********************************************
    logic [3:0] win_cnt_ff;
    logic       ta_wr;
    logic       rd_known;
    logic       ctrl_wr;
    assign ta_wr = sfr_wr && (sfr_addr == wdc_pkg::WDC_ADDR_TA);
    assign ctrl_wr = sfr_wr && (sfr_addr == wdc_pkg::WDC_ADDR_CTRL);
    assign rd_known = (sfr_addr == wdc_pkg::WDC_ADDR_TA) ||
                      (sfr_addr == wdc_pkg::WDC_ADDR_CTRL) ||
                      (sfr_addr == wdc_pkg::WDC_ADDR_EIE) ||
                      (sfr_addr == wdc_pkg::WDC_ADDR_EIP);

    // Any key write restarts the count, so a reload never looks too long
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_cnt_ff <= 4'h0;
        end else if (ta_wr || !ta_window_open) begin
            win_cnt_ff <= 4'h0;
        end else if (win_cnt_ff != 4'hf) begin
            win_cnt_ff <= win_cnt_ff + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_win_max_len: assert property (
        win_cnt_ff == 4'hc |-> !ta_window_open)
        else $error("key window open too long");
    a_win_min_len: assert property (
        $rose(ta_window_open) |-> ta_window_open [*8])
        else $error("key window closed early");
    a_win_cause: assert property (
        $rose(ta_window_open) |->
        $past(ta_wr && sfr_wdata == wdc_pkg::WDC_KEY_SECOND))
        else $error("key window opened without second key");
    a_key_readback: assert property (
        sfr_rd && sfr_addr == wdc_pkg::WDC_ADDR_TA |=> sfr_rdata == 8'hff)
        else $error("key register read wrong");
    a_ctrl_top_bit: assert property (
        sfr_rd && sfr_addr == wdc_pkg::WDC_ADDR_CTRL |=> sfr_rdata[7])
        else $error("control bit 7 read low");
    a_enable_reserved: assert property (
        sfr_rd && sfr_addr == wdc_pkg::WDC_ADDR_EIE |=>
        (sfr_rdata | 8'h10) == 8'hff)
        else $error("enable reserved bits low");
    a_prio_readback: assert property (
        sfr_rd && sfr_addr == wdc_pkg::WDC_ADDR_EIP |=>
        sfr_rdata == (8'hef | {3'h0, wd_irq_high_prio, 4'h0}))
        else $error("priority read disagrees with output");
    a_unmapped_zero: assert property (
        sfr_rd && !rd_known |=> sfr_rdata == wdc_pkg::WDC_RD_IDLE)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    a_urgent_cause: assert property (
        $rose(urgent_irq_req) |-> $past(urgent_irq_input || ctrl_wr))
        else $error("urgent request without cause");
    a_global_masks_wd: assert property (
        !global_irq_enable |-> !wd_irq_req)
        else $error("watchdog request while globally masked");
    a_reset_one_pulse: assert property (
        wd_cpu_reset |=> !wd_cpu_reset [*8])
        else $error("watchdog reset pulse too long");

    c_cpu_reset: cover property (wd_cpu_reset);
    c_window: cover property ($rose(ta_window_open));
    c_urgent_masked: cover property (urgent_irq_req && !global_irq_enable);
endmodule

bind wdc_ctrl wdc_ctrl_monitor #(.BASE_LOG2(BASE_LOG2)) u_wdc_ctrl_monitor (
    .core_clk(core_clk), .rst(rst), .ext_reset(ext_reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wd_period_sel(wd_period_sel),
    .urgent_irq_input(urgent_irq_input),
    .global_irq_enable(global_irq_enable), .urgent_irq_req(urgent_irq_req),
    .wd_irq_req(wd_irq_req), .wd_irq_high_prio(wd_irq_high_prio),
    .wd_cpu_reset(wd_cpu_reset), .ta_window_open(ta_window_open)
);
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       core_clk;
    logic       rst;
    logic       ext_reset;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic [1:0] wd_period_sel;
    logic       urgent_irq_input;
    logic       global_irq_enable;
    logic       urgent_irq_req;
    logic       wd_irq_req;
    logic       wd_irq_high_prio;
    logic       wd_cpu_reset;
    logic       ta_window_open;
    logic [7:0] rd_val;
    logic [7:0] old_val;
    int         n_cyc;
    int         err_count;
    int         n_checks;

    // Short base period keeps every watchdog scenario to a few thousand clocks
    wdc_ctrl #(.BASE_LOG2(4)) u_wdc_ctrl (
        .core_clk(core_clk), .rst(rst), .ext_reset(ext_reset),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .wd_period_sel(wd_period_sel), .urgent_irq_input(urgent_irq_input),
        .global_irq_enable(global_irq_enable),
        .urgent_irq_req(urgent_irq_req), .wd_irq_req(wd_irq_req),
        .wd_irq_high_prio(wd_irq_high_prio), .wd_cpu_reset(wd_cpu_reset),
        .ta_window_open(ta_window_open)
    );

    // ***********************************************
    // Clock, helpers and bus tasks
    // ***********************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] b8(input logic c);
        return {7'h0, c};
    endfunction

    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    // Data is registered at the taking edge, so it is read just after it
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask

    task automatic prot_ctrl(input logic [7:0] d);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_FIRST);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_SECOND);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, d);
    endtask

    task automatic pulse_urgent;
        @(posedge core_clk);
        urgent_irq_input <= 1'b1;
        @(posedge core_clk);
        urgent_irq_input <= 1'b0;
        #1;
    endtask

    task automatic wait_cpu_reset(input int limit, output int n);
        n = -1;
        for (int i = 1; i <= limit && n < 0; i++) begin
            @(posedge core_clk);
            #1;
            if (wd_cpu_reset === 1'b1) n = i;
        end
    endtask

    // ***********************************************
    // Scenarios
    // ***********************************************
    task automatic t_reset_values;
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, 8'hc0);
        sfr_read(wdc_pkg::WDC_ADDR_TA, rd_val);
        check(rd_val, 8'hff);
        sfr_read(8'h42, rd_val);
        check(rd_val, 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_EIE, 8'h00);
        sfr_read(wdc_pkg::WDC_ADDR_EIE, rd_val);
        check(rd_val, 8'hef);
        sfr_write(wdc_pkg::WDC_ADDR_EIP, 8'h10);
        sfr_read(wdc_pkg::WDC_ADDR_EIP, rd_val);
        check(rd_val, 8'hff);
        check(b8(wd_irq_high_prio), 8'h01);
    endtask

    task automatic t_protect;
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h63);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, 8'he0);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_SECOND);
        check(b8(ta_window_open), 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_FIRST);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h20);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_SECOND);
        check(b8(ta_window_open), 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_FIRST);
        sfr_write(wdc_pkg::WDC_ADDR_TA, wdc_pkg::WDC_KEY_SECOND);
        n_cyc = 0;
        repeat (20) begin
            if (ta_window_open === 1'b1) n_cyc++;
            @(posedge core_clk);
            #1;
        end
        check(8'(n_cyc), 8'(wdc_pkg::WDC_TA_WINDOW_CLK));
        prot_ctrl(8'h00);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, 8'h80);
    endtask

    task automatic t_urgent;
        pulse_urgent();
        check(b8(urgent_irq_req), 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h20);
        pulse_urgent();
        check(b8(urgent_irq_req), 8'h01);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, 8'hb0);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h20);
        check(b8(urgent_irq_req), 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h30);
        check(b8(urgent_irq_req), 8'h01);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_wd_irq;
        sfr_write(wdc_pkg::WDC_ADDR_EIE, 8'hff);
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        wd_period_sel <= 2'b00;
        repeat (40) @(posedge core_clk);
        #1;
        check(b8(wd_irq_req), 8'h01);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val & 8'h0c, 8'h08);
        @(posedge core_clk);
        global_irq_enable <= 1'b0;
        @(posedge core_clk);
        #1;
        check(b8(wd_irq_req), 8'h00);
        sfr_write(wdc_pkg::WDC_ADDR_EIE, 8'hef);
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        @(posedge core_clk);
        #1;
        check(b8(wd_irq_req), 8'h00);
    endtask

    task automatic t_wd_reset;
        @(posedge core_clk);
        wd_period_sel <= 2'b10;
        prot_ctrl(8'h03);
        wait_cpu_reset(2000, n_cyc);
        check(b8(n_cyc >= 1525 && n_cyc <= 1550), 8'h01);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val & 8'hf7, 8'h86);
        sfr_read(wdc_pkg::WDC_ADDR_EIE, rd_val);
        check(rd_val, 8'hef);
        wait_cpu_reset(2000, n_cyc);
        check(b8(n_cyc >= 1520 && n_cyc <= 1550), 8'h01);
        repeat (1100) @(posedge core_clk);
        prot_ctrl(8'h03);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val & 8'h01, 8'h00);
        wait_cpu_reset(700, n_cyc);
        check(b8(n_cyc == -1), 8'h01);
        @(posedge core_clk);
        wd_period_sel <= 2'b11;
    endtask

    task automatic t_ext_reset;
        prot_ctrl(8'h46);
        sfr_write(wdc_pkg::WDC_ADDR_CTRL, 8'h30);
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, old_val);
        @(posedge core_clk);
        ext_reset <= 1'b1;
        @(posedge core_clk);
        ext_reset <= 1'b0;
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, {1'b1, old_val[6], 1'b0, old_val[4], 1'b0,
                       old_val[2], old_val[1], 1'b0});
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        sfr_read(wdc_pkg::WDC_ADDR_CTRL, rd_val);
        check(rd_val, 8'hc0);
    endtask

    // ***********************************************
    // Main sequence and watchdog
    // ***********************************************
    initial begin
        err_count = 0;
        n_checks = 0;
        rst = 1'b1;
        ext_reset = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        wd_period_sel = 2'b11;
        urgent_irq_input = 1'b0;
        global_irq_enable = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_values();
        t_protect();
        t_urgent();
        t_wd_irq();
        t_wd_reset();
        t_ext_reset();
        tally_and_finish();
    end

    // Whole run needs under ten thousand clocks; a hang is cut well beyond
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
